// ==== sound_access_bridge.sv ====
`timescale 1ns/1ps
module sound_access_bridge
  import sound_bridge_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] hostAddr,
  input wire logic hostRead,
  input wire logic hostWrite,
  input wire logic [7:0] hostWrData,
  output logic [7:0] hostRdData,
  output logic hostSel,
  output logic [15:0] ramAddr,
  output logic [7:0] ramWrData,
  output logic ramReq,
  output logic ramWe,
  input wire logic ramGrant,
  input wire logic [7:0] ramRdData,
  output logic [7:0] oscAddr,
  output logic [7:0] oscWrData,
  output logic oscReq,
  output logic oscWe,
  input wire logic oscDone,
  input wire logic [7:0] oscRdData,
  output logic [3:0] volume
);
  logic [6:0] ctrl;
  logic busy;
  logic [7:0] ptrLo;
  logic [7:0] ptrHi;
  logic [15:0] ptrInc;
  logic [7:0] readLatch;
  xfer_state_t state;
  logic idle;
  logic dataAcc;
  logic ctrlWr;
  logic ptrLoWr;
  logic ptrHiWr;
  logic startRam;
  logic startOsc;
  logic ptrStep;
  logic ramEnd;
  logic oscEnd;

  // register map must be one aligned group of four
  if (CTRL_ADDR[1:0] != 2'b00 || PTRHI_ADDR != CTRL_ADDR + 16'h0003)
  begin : map_check
    $error("register map must be one aligned group of four");
  end

  // address decode
  always_comb
  begin
    hostSel = (hostAddr >= CTRL_ADDR) && (hostAddr <= PTRHI_ADDR);
  end
  assign dataAcc = (hostRead || hostWrite) && hostAddr == DATA_ADDR;
  assign ctrlWr = hostWrite && hostAddr == CTRL_ADDR;
  assign ptrLoWr = hostWrite && hostAddr == PTRLO_ADDR;
  assign ptrHiWr = hostWrite && hostAddr == PTRHI_ADDR;
  assign idle = state == IDLE_S;
  assign startRam = dataAcc && idle && ctrl[RAMSEL_BIT];
  assign startOsc = dataAcc && idle && !ctrl[RAMSEL_BIT];
  assign ramEnd = state == RAM_S && ramGrant;
  assign oscEnd = state == OSC_S && oscDone;
  assign ptrStep = (startRam || startOsc) && ctrl[AUTOINC_BIT];
  assign ptrInc = {ptrHi, ptrLo} + 16'h0001;

  // host read mux
  always_comb
  begin
    unique case (hostAddr)
      CTRL_ADDR: hostRdData = {busy, ctrl};
      DATA_ADDR: hostRdData = readLatch;
      PTRLO_ADDR: hostRdData = ptrLo;
      PTRHI_ADDR: hostRdData = ptrHi;
      default: hostRdData = 8'h00;
    endcase
  end

  // control register, bit 4 stored as written
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctrl <= CTRL_RESET;
    else if (ctrlWr)
      ctrl <= hostWrData[6:0];
  end
  assign volume = ctrl[VOL_MSB:0];

  // low pointer byte: host load or auto-increment
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ptrLo <= PTR_RESET;
    else if (ptrLoWr)
      ptrLo <= hostWrData;
    else if (ptrStep)
      ptrLo <= ptrInc[7:0];
  end

  // high pointer byte takes the carry of the low byte
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ptrHi <= PTR_RESET;
    else if (ptrHiWr)
      ptrHi <= hostWrData;
    else if (ptrStep)
      ptrHi <= ptrInc[15:8];
  end

  // transfer sequencer state
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state <= IDLE_S;
    else
    begin
      unique case (state)
        IDLE_S:
          if (startRam)
            state <= RAM_S;
          else if (startOsc)
            state <= OSC_S;
        RAM_S:
          if (ramGrant)
            state <= IDLE_S;
        OSC_S:
          if (oscDone)
            state <= IDLE_S;
        default:
          state <= IDLE_S;
      endcase
    end
  end

  // request toward sound RAM, held until granted
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ramReq <= 1'b0;
    else if (startRam)
      ramReq <= 1'b1;
    else if (ramEnd)
      ramReq <= 1'b0;
  end

  // RAM command captured at the start of a transfer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ramWe <= 1'b0;
      ramAddr <= {PTR_RESET, PTR_RESET};
      ramWrData <= DATA_RESET;
    end
    else if (startRam)
    begin
      ramWe <= hostWrite;
      ramAddr <= {ptrHi, ptrLo};
      ramWrData <= hostWrData;
    end
  end

  // request toward oscillator chip, held until done
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      oscReq <= 1'b0;
    else if (startOsc)
      oscReq <= 1'b1;
    else if (oscEnd)
      oscReq <= 1'b0;
  end

  // oscillator command captured at the start of a transfer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      oscWe <= 1'b0;
      oscAddr <= PTR_RESET;
      oscWrData <= DATA_RESET;
    end
    else if (startOsc)
    begin
      oscWe <= hostWrite;
      oscAddr <= ptrLo;
      oscWrData <= hostWrData;
    end
  end

  // fetched byte kept for the next data read
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      readLatch <= DATA_RESET;
    else if (ramEnd && !ramWe)
      readLatch <= ramRdData;
    else if (oscEnd && !oscWe)
      readLatch <= oscRdData;
  end

  // busy while an oscillator transfer is open
  assign busy = (state == OSC_S);
endmodule

// ==== sound_bridge_pkg.sv ====
package sound_bridge_pkg;
  localparam logic [15:0] CTRL_ADDR = 16'hc03c;
  localparam logic [15:0] DATA_ADDR = 16'hc03d;
  localparam logic [15:0] PTRLO_ADDR = 16'hc03e;
  localparam logic [15:0] PTRHI_ADDR = 16'hc03f;
  localparam int BUSY_BIT = 7;
  localparam int AUTOINC_BIT = 6;
  localparam int RAMSEL_BIT = 5;
  localparam int RSVD_BIT = 4;
  localparam int VOL_MSB = 3;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  typedef enum logic [1:0]
  {
    IDLE_S = 2'b00,
    RAM_S = 2'b01,
    OSC_S = 2'b10
  } xfer_state_t;
endpackage

// ==== sound_bridge_properties.sv ====
`timescale 1ns/1ps
module sound_bridge_properties
  import sound_bridge_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] hostAddr,
  input wire logic hostWrite,
  input wire logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  input wire logic hostSel,
  input wire logic ramReq,
  input wire logic ramGrant,
  input wire logic oscReq,
  input wire logic oscDone,
  input wire logic [7:0] oscAddr,
  input wire logic [3:0] volume
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sel_decode_a: assert property (
    hostSel == (hostAddr[15:2] == 14'h300f))
    else $error("decode");
  busy_flag_a: assert property (
    hostAddr == CTRL_ADDR |-> hostRdData[7] == oscReq)
    else $error("busy");
  volume_load_a: assert property (
    hostWrite && hostAddr == CTRL_ADDR
    |=> {4'h0, volume} == ($past(hostWrData) & 8'h0f))
    else $error("volume");
  one_target_a: assert property (!(ramReq && oscReq))
    else $error("target");
  ram_end_a: assert property (ramReq && ramGrant |=> !ramReq)
    else $error("ram end");
  osc_hold_a: assert property (
    oscReq && !oscDone |=> oscReq && $stable(oscAddr))
    else $error("osc hold");
  osc_end_a: assert property (oscReq && oscDone |=> !oscReq)
    else $error("osc end");
  data_start_a: assert property (
    hostWrite && hostAddr == DATA_ADDR && !ramReq && !oscReq
    |=> ramReq || oscReq)
    else $error("start");
endmodule
bind sound_access_bridge sound_bridge_properties i_props(.core_clk, .rst,
  .hostAddr, .hostWrite, .hostWrData, .hostRdData, .hostSel, .ramReq,
  .ramGrant, .oscReq, .oscDone, .oscAddr, .volume);

// ==== sound_far_side.sv ====
`timescale 1ns/1ps
module sound_far_side #(parameter int AW = 16)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wd,
  input wire logic [1:0] dly,
  output logic ack,
  output logic [7:0] rd
);
  logic [7:0] m [2**AW];
  logic [2:0] c;
  wire go = req && !ack && c >= {1'b0, dly};
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      ack <= 1'b0;
      c <= 3'h0;
      rd <= 8'h00;
    end
    else
    begin
      c <= (req && !ack) ? c + 3'h1 : 3'h0;
      ack <= go;
      rd <= go ? m[addr] : ~rd;
      if (go && we)
        m[addr] <= wd;
    end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench import sound_bridge_pkg::*;;
  logic core_clk, rst, hostRead, hostWrite, hostSel, ramReq, ramWe, ramGrant;
  logic oscReq, oscWe, oscDone;
  logic [15:0] hostAddr, ramAddr, p, q;
  logic [7:0] hostWrData, hostRdData, ramWrData, ramRdData, r, late;
  logic [7:0] oscAddr, oscWrData, oscRdData;
  logic [3:0] volume;
  logic [31:0] s = 32'h5eff;
  logic [1:0] dly;
  logic [6:0] c;
  int n_errors, samples_checked;
  logic [7:0] m [int];
  sound_access_bridge i_dut(.*);
  sound_far_side i_ram(.core_clk, .rst, .req(ramReq), .we(ramWe), .dly,
    .addr(ramAddr), .wd(ramWrData), .ack(ramGrant), .rd(ramRdData));
  sound_far_side #(.AW(8)) i_osc(.core_clk, .rst, .req(oscReq), .we(oscWe),
    .addr(oscAddr), .wd(oscWrData), .dly(~dly), .ack(oscDone), .rd(oscRdData));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int key();
    return c[5] ? int'(p) : 32'h10000 + p[7:0];
  endfunction
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    hostAddr <= a;
    hostWrite <= w;
    hostRead <= !w;
    hostWrData <= d;
    #1 r = hostRdData;
    @(posedge core_clk);
    hostWrite <= 1'b0;
    hostRead <= 1'b0;
    #1;
  endtask
  task automatic step;
    int k;
    if (c[6])
      p = p + 16'h1;
    r = 8'hff;
    for (k = 0; k < 30 && !(r[7] === 1'b0 && ramReq === 1'b0); k++)
      acc(CTRL_ADDR, 1'b0, 8'h00);
    if (k == 30)
    begin
      n_errors++;
      conclude;
    end
  endtask
  initial
  begin
    rst = 1'b1;
    {hostAddr, hostRead, hostWrite, hostWrData, dly, late} = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    acc(CTRL_ADDR, 1'b0, 8'h00);
    chk(r, 8'h00);
    acc(16'hc040, 1'b0, 8'h00);
    chk(r, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      s = nx(s);
      c = {i[1:0], s[4:0]};
      dly <= s[9:8];
      q = i[2] ? 16'hfffe : s[31:16];
      acc(CTRL_ADDR, 1'b1, {1'b0, c});
      chk({4'h0, volume}, {4'h0, c[3:0]});
      for (int j = 0; j < 8; j++)
      begin
        if (j % 4 == 0)
        begin
          p = q;
          acc(PTRLO_ADDR, 1'b1, p[7:0]);
          acc(PTRHI_ADDR, 1'b1, p[15:8]);
        end
        s = nx(s);
        acc(DATA_ADDR, j < 4, s[7:0]);
        if (j >= 4)
          chk(r, late);
        if (j < 4)
          m[key()] = s[7:0];
        else
          late = m[key()];
        step;
      end
      acc(PTRLO_ADDR, 1'b0, 8'h00);
      chk(r, p[7:0]);
      acc(PTRHI_ADDR, 1'b0, 8'h00);
      chk(r, p[15:8]);
      acc(CTRL_ADDR, 1'b0, 8'h00);
      chk(r, {1'b0, c});
    end
    conclude;
  end
endmodule
